/* verilog/port_pin_function_mux.sv */
// Pin-function multiplexer for the five general ports and external bus.
// Assumes the core supplies port latches, bus cycle requests and strobes
// on i_clk; pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps

// How it works
// [R01] Low port drives address/data during external cycles
// [R02] Otherwise low port outputs only pull low
// [R03] High port drives upper address, both ways
// [R04] Fourth port pull-up I/O with alternates
// [R05] Fourth bits 0/1 serial receive, transmit
// [R06] Fourth bits 2/3 external interrupts zero, one
// [R07] Fourth bits 4/5 timer zero/one counts
// [R08] Fourth bits 6/7 write, read strobes
// [R09] Extra nibble port, bits 2/3 interrupts
// [R10] Separate 64K code and data spaces
// [R11] Second bits 0/1 timer two inputs
// [R12] Internal code hidden when access pin high
// [R13] Program strobe only for external code
// [R14] Alternates need port latch bit one
module port_pin_function_mux #(
    parameter logic [15:0] CODE_TOP = port_mux_pkg::INT_CODE_TOP
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_p0_latch,
    input wire logic [7:0] i_p1_latch,
    input wire logic [7:0] i_p2_latch,
    input wire logic [7:0] i_p3_latch,
    input wire logic [3:0] i_p4_latch,
    input wire logic i_code_req,
    input wire logic i_data_req,
    input wire logic i_data_wr,
    input wire logic [15:0] i_bus_addr,
    input wire logic [7:0] i_bus_wdata,
    input wire logic i_addr_phase,
    input wire logic i_strobe_phase,
    input wire logic i_serial_tx,
    input wire logic i_external_access_pin,
    input wire logic [7:0] i_p0_pin,
    input wire logic [7:0] i_p1_pin,
    input wire logic [7:0] i_p2_pin,
    input wire logic [7:0] i_p3_pin,
    input wire logic [3:0] i_p4_pin,
    output logic [7:0] o_p0_out,
    output logic [7:0] o_p0_oe,
    output logic [7:0] o_p1_out,
    output logic [7:0] o_p1_oe,
    output logic [7:0] o_p2_out,
    output logic [7:0] o_p2_oe,
    output logic [7:0] o_p3_out,
    output logic [7:0] o_p3_oe,
    output logic [3:0] o_p4_out,
    output logic [3:0] o_p4_oe,
    output logic o_program_store_strobe_n,
    output logic o_code_external,
    output logic [7:0] o_p0_in,
    output logic [7:0] o_p1_in,
    output logic [7:0] o_p2_in,
    output logic [7:0] o_p3_in,
    output logic [3:0] o_p4_in,
    output logic o_serial_rx,
    output logic o_ext_irq_zero_pin,
    output logic o_ext_irq_one_pin,
    output logic o_ext_irq_two_pin,
    output logic o_ext_irq_three_pin,
    output logic o_timer_zero_count_pin,
    output logic o_timer_one_count_pin,
    output logic o_timer_two_count_pin,
    output logic o_timer_two_reload_pin
);
    logic [36:0] s1_r, s1_nxt, s2_r, s2_nxt;
    logic [7:0] p0_out_r, p0_out_nxt, p0_oe_r, p0_oe_nxt;
    logic [7:0] p2_out_r, p2_out_nxt, p2_oe_r, p2_oe_nxt;
    logic [7:0] p1_out_r, p1_out_nxt, p1_oe_r, p1_oe_nxt;
    logic [7:0] p3_out_r, p3_out_nxt, p3_oe_r, p3_oe_nxt;
    logic [3:0] p4_out_r, p4_out_nxt, p4_oe_r, p4_oe_nxt;
    logic program_store_strobe_n_r, program_store_strobe_n_nxt, ext_r, ext_nxt;
    logic ea_sync, code_ext, bus_busy;
    logic [7:0] in0, in1, in2, in3;
    logic [3:0] in4;

    // Weak pull-up ports: drive a low for a latch zero, drive a short
    // high only on a 0->1 change; otherwise the pull-up holds the pin.
    function automatic logic [7:0] pull_oe(input logic [7:0] v,
                                           input logic [7:0] prev);
        pull_oe = ~v | (v & ~prev);
    endfunction

    if (CODE_TOP == 16'h0000) begin
        $error("CODE_TOP must be nonzero");
    end

    // Pins pass two flops before anything reads them
    always_comb begin
        s1_nxt = {i_external_access_pin, i_p4_pin, i_p3_pin, i_p2_pin,
                  i_p1_pin, i_p0_pin};
        s2_nxt = s1_r;
    end

    assign ea_sync = s2_r[36];
    assign in4 = s2_r[35:32];
    assign in3 = s2_r[31:24];
    assign in2 = s2_r[23:16];
    assign in1 = s2_r[15:8];
    assign in0 = s2_r[7:0];

    // [R12] internal code hidden
    assign code_ext = ~ea_sync | (i_bus_addr > CODE_TOP);
    // [R10] code and data spaces
    assign bus_busy = (i_code_req & code_ext) | i_data_req;

    always_comb begin
        p0_out_nxt = i_p0_latch;
        p0_oe_nxt = ~i_p0_latch;
        p2_out_nxt = i_p2_latch;
        p2_oe_nxt = pull_oe(i_p2_latch, p2_out_r);
        ext_nxt = i_code_req & code_ext;
        program_store_strobe_n_nxt = 1'b1;
        // [R02] open-drain low only
        if (!bus_busy) begin
            p0_out_nxt = i_p0_latch;
            p0_oe_nxt = ~i_p0_latch;
        end else begin
            // [R03] upper address strong
            p2_out_nxt = i_bus_addr[15:8];
            p2_oe_nxt = 8'hff;
            // [R01] strong address/data
            if (i_addr_phase) begin
                p0_out_nxt = i_bus_addr[7:0];
                p0_oe_nxt = 8'hff;
            end else if (i_data_req && i_data_wr) begin
                p0_out_nxt = i_bus_wdata;
                p0_oe_nxt = 8'hff;
            end else begin
                p0_out_nxt = 8'h00;
                p0_oe_nxt = 8'h00;
            end
            // [R13] strobe external code only
            program_store_strobe_n_nxt = ~(i_code_req & code_ext & i_strobe_phase);
        end
    end

    always_comb begin
        logic [7:0] v3;
        logic [7:0] v4;
        v3 = i_p3_latch;
        v4 = pull_oe({4'h0, i_p4_latch}, {4'h0, p4_out_r});
        // [R05] serial transmit gated
        v3[port_mux_pkg::P3_TXD] = i_p3_latch[port_mux_pkg::P3_TXD]
                                   & i_serial_tx;
        // [R08] data memory strobes
        v3[port_mux_pkg::P3_WRS] = i_p3_latch[port_mux_pkg::P3_WRS]
            & ~(i_data_req & i_data_wr & i_strobe_phase);
        v3[port_mux_pkg::P3_RDS] = i_p3_latch[port_mux_pkg::P3_RDS]
            & ~(i_data_req & ~i_data_wr & i_strobe_phase);
        // [R04] pull-up port
        p3_out_nxt = v3;
        p3_oe_nxt = pull_oe(v3, p3_out_r);
        p1_out_nxt = i_p1_latch;
        p1_oe_nxt = pull_oe(i_p1_latch, p1_out_r);
        // [R09] nibble port
        p4_out_nxt = i_p4_latch;
        p4_oe_nxt = v4[3:0];
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            s1_r <= '1;
            s2_r <= '1;
            p0_out_r <= port_mux_pkg::LATCH_RST;
            p0_oe_r <= 8'h00;
            p1_out_r <= port_mux_pkg::LATCH_RST;
            p1_oe_r <= 8'h00;
            p2_out_r <= port_mux_pkg::LATCH_RST;
            p2_oe_r <= 8'h00;
            p3_out_r <= port_mux_pkg::LATCH_RST;
            p3_oe_r <= 8'h00;
            p4_out_r <= port_mux_pkg::NIB_RST;
            p4_oe_r <= 4'h0;
            program_store_strobe_n_r <= 1'b1;
            ext_r <= 1'b0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            p0_out_r <= p0_out_nxt;
            p0_oe_r <= p0_oe_nxt;
            p1_out_r <= p1_out_nxt;
            p1_oe_r <= p1_oe_nxt;
            p2_out_r <= p2_out_nxt;
            p2_oe_r <= p2_oe_nxt;
            p3_out_r <= p3_out_nxt;
            p3_oe_r <= p3_oe_nxt;
            p4_out_r <= p4_out_nxt;
            p4_oe_r <= p4_oe_nxt;
            program_store_strobe_n_r <= program_store_strobe_n_nxt;
            ext_r <= ext_nxt;
        end
    end

    assign o_p0_out = p0_out_r;
    assign o_p0_oe = p0_oe_r;
    assign o_p1_out = p1_out_r;
    assign o_p1_oe = p1_oe_r;
    assign o_p2_out = p2_out_r;
    assign o_p2_oe = p2_oe_r;
    assign o_p3_out = p3_out_r;
    assign o_p3_oe = p3_oe_r;
    assign o_p4_out = p4_out_r;
    assign o_p4_oe = p4_oe_r;
    assign o_program_store_strobe_n = program_store_strobe_n_r;
    assign o_code_external = ext_r;
    assign o_p0_in = in0;
    assign o_p1_in = in1;
    assign o_p2_in = in2;
    assign o_p3_in = in3;
    assign o_p4_in = in4;

    // [R14] inputs gated by latch one; a zero latch forces idle high, or low on the count inputs
    // so a driven-low pin never looks like an event.
    assign o_serial_rx = in3[port_mux_pkg::P3_RXD]
                         | ~i_p3_latch[port_mux_pkg::P3_RXD];
    // [R06] interrupt zero/one inputs
    assign o_ext_irq_zero_pin = in3[port_mux_pkg::P3_IRQ0]
                                | ~i_p3_latch[port_mux_pkg::P3_IRQ0];
    assign o_ext_irq_one_pin = in3[port_mux_pkg::P3_IRQ1]
                               | ~i_p3_latch[port_mux_pkg::P3_IRQ1];
    // [R07] timer count inputs
    assign o_timer_zero_count_pin = in3[port_mux_pkg::P3_CNT0]
                                    & i_p3_latch[port_mux_pkg::P3_CNT0];
    assign o_timer_one_count_pin = in3[port_mux_pkg::P3_CNT1]
                                   & i_p3_latch[port_mux_pkg::P3_CNT1];
    // [R09] interrupt two/three inputs
    assign o_ext_irq_two_pin = in4[port_mux_pkg::P4_IRQ2]
                               | ~i_p4_latch[port_mux_pkg::P4_IRQ2];
    assign o_ext_irq_three_pin = in4[port_mux_pkg::P4_IRQ3]
                                 | ~i_p4_latch[port_mux_pkg::P4_IRQ3];
    // [R11] timer two inputs
    assign o_timer_two_count_pin = in1[port_mux_pkg::P1_CNT2]
                                   & i_p1_latch[port_mux_pkg::P1_CNT2];
    assign o_timer_two_reload_pin = in1[port_mux_pkg::P1_RLD2]
                                    | ~i_p1_latch[port_mux_pkg::P1_RLD2];

    // Assertions
    open_drain_a: // [R02]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !$past(bus_busy) |-> ((p0_oe_r & p0_out_r) == 8'h00))
        else $error("low port drove high outside bus cycle");
    addr_strong_a: // [R01]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (bus_busy && i_addr_phase) |=> (p0_oe_r == 8'hff
            && p0_out_r == $past(i_bus_addr[7:0])))
        else $error("low address not driven strongly");
    high_addr_a: // [R03]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        bus_busy |=> (p2_oe_r == 8'hff
            && p2_out_r == $past(i_bus_addr[15:8])))
        else $error("upper address not driven");
    program_store_strobe_int_a: // [R13]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_code_req && !code_ext) |=> program_store_strobe_n_r)
        else $error("program strobe on internal fetch");
    ea_hide_a: // [R12]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (ea_sync && i_bus_addr <= CODE_TOP && !i_data_req)
            |=> (p2_oe_r != 8'hff || p2_out_r == $past(i_p2_latch)))
        else $error("internal code leaked to bus");
    wr_strobe_a: // [R08]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_data_req && i_data_wr && i_strobe_phase)
            |=> !p3_out_r[port_mux_pkg::P3_WRS])
        else $error("write strobe missing");
    latch_gate_a: // [R14]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !i_p3_latch[port_mux_pkg::P3_CNT0] |-> !o_timer_zero_count_pin)
        else $error("count input not gated by latch");
    irq_two_a: // [R09]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_p4_latch[port_mux_pkg::P4_IRQ2] && !in4[port_mux_pkg::P4_IRQ2])
            |-> !o_ext_irq_two_pin)
        else $error("interrupt two not passed");
    tx_a: // [R05]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !i_serial_tx |=> !p3_out_r[port_mux_pkg::P3_TXD])
        else $error("transmit not driven");
    ext_fetch_c: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        i_code_req && code_ext && i_strobe_phase ##1 !program_store_strobe_n_r);
    data_rd_c: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        i_data_req && !i_data_wr && i_strobe_phase);
    gpio_c: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        !bus_busy ##1 p0_oe_r != 8'h00);
endmodule

/* verilog/port_mux_pkg.sv */
// Constants for the port pin-function multiplexer.
// Assumes a single core clock and a synchronous active-low reset.
package port_mux_pkg;
    localparam int unsigned PORT_W = 8;
    localparam int unsigned NIB_W = 4;
    localparam int unsigned ADDR_W = 16;
    // Bit positions on the fourth port
    localparam int unsigned P3_RXD = 0;
    localparam int unsigned P3_TXD = 1;
    localparam int unsigned P3_IRQ0 = 2;
    localparam int unsigned P3_IRQ1 = 3;
    localparam int unsigned P3_CNT0 = 4;
    localparam int unsigned P3_CNT1 = 5;
    localparam int unsigned P3_WRS = 6;
    localparam int unsigned P3_RDS = 7;
    // Bit positions on the second and extra ports
    localparam int unsigned P1_CNT2 = 0;
    localparam int unsigned P1_RLD2 = 1;
    localparam int unsigned P4_IRQ2 = 2;
    localparam int unsigned P4_IRQ3 = 3;
    // Latch values after reset
    localparam logic [7:0] LATCH_RST = 8'hff;
    localparam logic [3:0] NIB_RST = 4'hf;
    // Default top of internal program memory
    localparam logic [15:0] INT_CODE_TOP = 16'h3fff;
endpackage

/* test/ext_board_model.sv */
// Board and external memory seen by the port multiplexer.
// Assumes pull-ups on every port; memory answers while the strobe is low.
`timescale 1ns/1ps
module ext_board_model #(
    parameter logic [7:0] CODE_BYTE = 8'ha5
) (
    input wire logic [7:0] i_p0_out,
    input wire logic [7:0] i_p0_oe,
    input wire logic [7:0] i_p1_out,
    input wire logic [7:0] i_p1_oe,
    input wire logic [7:0] i_p3_out,
    input wire logic [7:0] i_p3_oe,
    input wire logic [3:0] i_p4_out,
    input wire logic [3:0] i_p4_oe,
    input wire logic i_program_store_strobe_n,
    input wire logic [7:0] i_board_p1,
    input wire logic [7:0] i_board_p3,
    input wire logic [3:0] i_board_p4,
    output logic [7:0] o_p0_pin,
    output logic [7:0] o_p1_pin,
    output logic [7:0] o_p3_pin,
    output logic [3:0] o_p4_pin
);
    logic [7:0] p0_float;
    // Open-drain low port needs the board pull-up for a high level
    assign p0_float = i_program_store_strobe_n ? 8'hff : CODE_BYTE;
    assign o_p0_pin = (i_p0_out & i_p0_oe) | (p0_float & ~i_p0_oe);
    assign o_p1_pin = (i_p1_out & i_p1_oe) | (i_board_p1 & ~i_p1_oe);
    assign o_p3_pin = (i_p3_out & i_p3_oe) | (i_board_p3 & ~i_p3_oe);
    assign o_p4_pin = (i_p4_out & i_p4_oe) | (i_board_p4 & ~i_p4_oe);
endmodule

/* test/port_pin_function_mux_tb.sv */
// Self-checking bench for the port pin-function multiplexer.
// Assumes the design defaults and the board model beside it.
`timescale 1ns/1ps
module port_pin_function_mux_tb;
    logic i_clk = 1'b0, i_reset_n = 1'b0;
    logic [7:0] l0 = 8'hff, l1 = 8'hff, l2 = 8'hff, l3 = 8'hff;
    logic [3:0] l4 = 4'hf, b4 = 4'hf, p4p, p4o, p4e, p4i;
    logic creq = 0, dreq = 0, dwr = 0, aph = 0, sph = 0, tx = 1, ea = 1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wd = 8'h00, b1 = 8'hff, b3 = 8'hff;
    logic [7:0] p0p, p1p, p3p, p0o, p0e, p1o, p1e, p2o, p2e, p3o, p3e, p0i;
    logic psn, cext, rx, iq0, iq1, iq2, iq3, c0, c1, c2, r2;
    int fails = 0, check_count = 0;
    always #12.5 i_clk = ~i_clk;
    port_pin_function_mux port_pin_function_mux_i (.i_clk(i_clk),
        .i_reset_n(i_reset_n), .i_p0_latch(l0), .i_p1_latch(l1),
        .i_p2_latch(l2), .i_p3_latch(l3), .i_p4_latch(l4),
        .i_code_req(creq), .i_data_req(dreq), .i_data_wr(dwr),
        .i_bus_addr(addr), .i_bus_wdata(wd), .i_addr_phase(aph),
        .i_strobe_phase(sph), .i_serial_tx(tx),
        .i_external_access_pin(ea), .i_p0_pin(p0p), .i_p1_pin(p1p),
        .i_p2_pin(p2o), .i_p3_pin(p3p), .i_p4_pin(p4p), .o_p0_out(p0o),
        .o_p0_oe(p0e), .o_p1_out(p1o), .o_p1_oe(p1e), .o_p2_out(p2o),
        .o_p2_oe(p2e), .o_p3_out(p3o), .o_p3_oe(p3e), .o_p4_out(p4o),
        .o_p4_oe(p4e), .o_program_store_strobe_n(psn),
        .o_code_external(cext), .o_p0_in(p0i), .o_p1_in(), .o_p2_in(),
        .o_p3_in(), .o_p4_in(p4i), .o_serial_rx(rx),
        .o_ext_irq_zero_pin(iq0), .o_ext_irq_one_pin(iq1),
        .o_ext_irq_two_pin(iq2), .o_ext_irq_three_pin(iq3),
        .o_timer_zero_count_pin(c0), .o_timer_one_count_pin(c1),
        .o_timer_two_count_pin(c2), .o_timer_two_reload_pin(r2));
    ext_board_model ext_board_model_i (.i_p0_out(p0o), .i_p0_oe(p0e),
        .i_p1_out(p1o), .i_p1_oe(p1e), .i_p3_out(p3o), .i_p3_oe(p3e),
        .i_p4_out(p4o), .i_p4_oe(p4e), .i_program_store_strobe_n(psn),
        .i_board_p1(b1), .i_board_p3(b3), .i_board_p4(b4),
        .o_p0_pin(p0p), .o_p1_pin(p1p), .o_p3_pin(p3p), .o_p4_pin(p4p));
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_gpio;
        l0 = 8'h0f;
        l3 = 8'hef;
        step(2);
        check("p0_oe", p0e, 8'hf0);
        check("p0_out", p0o & p0e, 8'h00);
        check("p3_drive", {p3e[4], p3o[4]}, 2'b10);
        l0 = 8'hff;
        l3 = 8'hff;
        step(3);
        $display("test gpio done");
    endtask
    task automatic t_fetch(input logic [15:0] a, input logic e,
                           input logic ext);
        ea = e;
        step(3);
        creq = 1;
        addr = a;
        aph = 1;
        step(1);
        // Code goes external outside internal memory or with the access pin low
        check("code_ext", cext, ext);
        if (ext) begin
            check("p0_addr", {p0e, p0o}, {8'hff, a[7:0]});
            check("p2_addr", {p2e, p2o}, {8'hff, a[15:8]});
        end
        aph = 0;
        sph = 1;
        step(1);
        check("strobe_n", psn, !ext);
        if (ext) check("p0_release", p0e, 8'h00);
        creq = 0;
        sph = 0;
        step(1);
        check("strobe_idle", psn, 1'b1);
        step(1);
        // Code byte read back through the low port
        check("code_in", p0i, ext ? 8'ha5 : 8'hff);
        $display("test fetch %h done", a);
    endtask
    task automatic t_data(input logic w);
        dreq = 1;
        dwr = w;
        addr = 16'hfedc;
        wd = 8'h5a;
        aph = 1;
        step(1);
        check("data_addr", {p2o, p0o}, 16'hfedc);
        aph = 0;
        sph = 1;
        step(1);
        if (w) begin
            check("wr_strobe", {p0e, p0o, p3o[6]},
                  {8'hff, 8'h5a, 1'b0});
        end else begin
            check("rd_strobe", p3o[7], 1'b0);
        end
        dreq = 0;
        sph = 0;
        step(2);
        check("strobes_idle", p3o[7:6], 2'b11);
        $display("test data %0d done", w);
    endtask
    task automatic t_alt;
        b3 = 8'h2a;
        b1 = 8'h02;
        b4 = 4'h4;
        tx = 0;
        step(3);
        check("serial", {rx, p3o[1]}, 2'b00);
        check("p3_alt", {iq0, iq1, c0, c1}, 4'b0101);
        check("p1_alt", {c2, r2}, 2'b01);
        check("p4_alt", {iq2, iq3, p4i}, 6'h24);
        l3 = 8'hc3;
        step(3);
        check("alt_off", {iq0, iq1, c0, c1}, 4'b1100);
        l3 = 8'hff;
        tx = 1;
        step(2);
        $display("test alternates done");
    endtask
    initial begin
        #100000;
        fails++;
        wrap_up();
    end
    initial begin
        step(3);
        check("reset", {p0e, p2e, psn, cext}, 18'h00002);
        i_reset_n = 1;
        step(3);
        t_gpio();
        t_fetch(16'h4000, 1, 1);
        t_fetch(16'h0100, 1, 0);
        t_fetch(16'h0100, 0, 1);
        t_data(1);
        t_data(0);
        t_alt();
        wrap_up();
    end
endmodule
